// ==== ppp_port.sv ====
// Overview of operation
// - With drivers on each data latch bit drives its pin, 0 low, 1 high.
// - Data reads return the latch when driving, else the live pin levels.
// - Port 250H writes the data latch and reads the data sample.
// - Port 260H writes the control register and reads the status port.
// - Control bits 0-3 set pull the strobe, newline, init, online pins low.
// - Control bit 4 clear enables the data drivers; set releases the pins.
// - Control bit 7 clear requests an interrupt while busy is low.
// - The interrupt is serviced through the vector at 0:98H.
// - Every status bit reads the inverse of its pin level.
// - Status bits: busy_n ack fault media_n online_n strobe init select.
//
// Purpose : Parallel printer port behind two I/O addresses
// Assumes : Pins sampled synchronously; open-collector pins pulled up
// Notes   : Read data is registered, valid the cycle after io_rd
`timescale 1ns/100ps
`include "ppp_params.svh"

module ppp_port (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Host I/O bus
  input  wire logic [15:0]                io_addr,
  input  wire logic                       io_wr,
  input  wire logic                       io_rd,
  input  wire logic [7:0]                 io_wdata,
  output      logic [7:0]                 io_rdata,
  output      logic                       irq,
  output      logic [19:0]                irq_vector_addr,
  // Data pins, three signals each
  input  wire logic [7:0]                 data_i,
  output      logic [7:0]                 data_o,
  output      logic                       data_oe,
  // Open-collector control pins, enable pulls the pin low
  input  wire logic [3:0]                 ctrl_pin_i,
  output      ppp_pkg::ppp_ctrl_pins_type ctrl_oe,
  // Status input pins
  input  wire ppp_pkg::ppp_status_in_type stat_i
);

  ppp_pkg::ppp_state_type s_q;
  ppp_pkg::ppp_state_type s_d;
  logic [7:0]             ctl_next;
  logic [7:0]             data_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    data_next = s_q.data_out_latch;
    ctl_next  = s_q.line_control;
    if (io_wr && io_addr == `PPP_DATA_ADDR) begin
      data_next = io_wdata;
    end
    if (io_wr && io_addr == `PPP_CTRL_ADDR) begin
      // Unused bits 5 and 6 are dropped so they read back nowhere
      ctl_next = io_wdata & 8'h9f;
    end
    s_d.data_out_latch = data_next;
    s_d.line_control   = ctl_next;
    // Pins follow the registers one cycle after the write
    s_d.data_o  = data_next;
    s_d.data_oe = ~ctl_next[`PPP_CTL_OUTDIS];
    s_d.ctrl.strobe_oe       = ctl_next[`PPP_CTL_STROBE];
    s_d.ctrl.auto_newline_oe = ctl_next[`PPP_CTL_AUTONL];
    s_d.ctrl.init_oe         = ctl_next[`PPP_CTL_INIT];
    s_d.ctrl.online_req_oe   = ctl_next[`PPP_CTL_ONLINE];
    // Level request: stays up as long as busy is low and unmasked
    s_d.irq = ~s_q.line_control[`PPP_CTL_INTDIS] & ~stat_i.busy;
    s_d.rd_data = 8'h00;
    if (io_rd && io_addr == `PPP_DATA_ADDR) begin
      s_d.rd_data = s_q.data_oe ? s_q.data_out_latch : data_i;
    end else if (io_rd && io_addr == `PPP_CTRL_ADDR) begin
      // Bits 5-7 read the open-collector pins themselves
      s_d.rd_data = ~{ctrl_pin_i[`PPP_CTL_ONLINE],
                      ctrl_pin_i[`PPP_CTL_INIT],
                      ctrl_pin_i[`PPP_CTL_STROBE],
                      stat_i.online, stat_i.media_exhausted,
                      stat_i.fault, stat_i.ack, stat_i.busy};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q                <= '0;
      s_q.data_out_latch <= `PPP_DATA_RST;
      s_q.line_control   <= `PPP_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all but the constant vector address straight from the state register
  // ----------------------------------------------------------------
  assign io_rdata        = s_q.rd_data;
  assign irq             = s_q.irq;
  assign data_o          = s_q.data_o;
  assign data_oe         = s_q.data_oe;
  assign ctrl_oe         = s_q.ctrl;
  assign irq_vector_addr = `PPP_INT_VEC_ADDR;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence ctl_write_seq;
    io_wr && io_addr == `PPP_CTRL_ADDR;
  endsequence

  sequence stat_read_seq;
    io_rd && io_addr == `PPP_CTRL_ADDR;
  endsequence

  sequence unmapped_read_seq;
    io_rd && io_addr != `PPP_DATA_ADDR && io_addr != `PPP_CTRL_ADDR;
  endsequence

  chk_data_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_wr && io_addr == `PPP_DATA_ADDR |=> data_o == $past(io_wdata))
    else $error("data pins do not follow written byte");

  chk_read_mux: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_rd && io_addr == `PPP_DATA_ADDR && !data_oe |=>
    io_rdata == $past(data_i))
    else $error("data read does not return pin levels");

  chk_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_rd && io_addr == `PPP_DATA_ADDR && data_oe |=>
    io_rdata == data_o)
    else $error("data read does not return latch");

  chk_out_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl_write_seq |=> data_oe == !$past(io_wdata[4]))
    else $error("driver enable wrong after control write");

  chk_strobe_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl_write_seq |=> ctrl_oe.strobe_oe == $past(io_wdata[0]) &&
    ctrl_oe.online_req_oe == $past(io_wdata[3]))
    else $error("control pins wrong after control write");

  chk_irq_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_q.line_control[`PPP_CTL_INTDIS] |=> !irq)
    else $error("masked port raised interrupt");

  chk_irq_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s_q.line_control[7] && !stat_i.busy |=> irq)
    else $error("interrupt missing while busy low");

  chk_status_inv: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_rd && io_addr == `PPP_CTRL_ADDR |=>
    io_rdata[0] == !$past(stat_i.busy) &&
    io_rdata[3] == !$past(stat_i.media_exhausted))
    else $error("status bits not inverted pin levels");

  chk_unused_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl_write_seq |=> s_q.line_control[6:5] == 2'h0)
    else $error("unused control bits stored");

  // ----------------------------------------------------------------
  // Further checks on pins and read paths
  // ----------------------------------------------------------------
  // The remaining two open-collector pins follow their control bits
  chk_newline_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl_write_seq |=> ctrl_oe.auto_newline_oe == $past(io_wdata[1]) &&
    ctrl_oe.init_oe == $past(io_wdata[2]))
    else $error("newline or init pin wrong after control write");

  // Upper status bits see the pins, so a stuck pin shows up here
  chk_status_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stat_read_seq |=> io_rdata[7:5] ==
    ~$past({ctrl_pin_i[3], ctrl_pin_i[2], ctrl_pin_i[0]}))
    else $error("status pin bits not inverted pin levels");

  chk_status_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stat_read_seq |=> io_rdata[1] == !$past(stat_i.ack) &&
    io_rdata[2] == !$past(stat_i.fault) &&
    io_rdata[4] == !$past(stat_i.online))
    else $error("ack, fault or online status bit wrong");

  // Foreign addresses must never leak a register onto the bus
  chk_unmapped_rd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    unmapped_read_seq |=> io_rdata == 8'h00)
    else $error("unmapped read returned data");

  chk_idle_rdata: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !io_rd |=> io_rdata == 8'h00)
    else $error("read data without a read strobe");

  // Pins only move on a write to their own register
  chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(io_wr && io_addr == `PPP_DATA_ADDR) |=> $stable(data_o))
    else $error("data pins moved without a data write");

  chk_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(io_wr && io_addr == `PPP_CTRL_ADDR) |=>
    $stable(ctrl_oe) && $stable(data_oe))
    else $error("control pins moved without a control write");

  // A busy printer must drop the level request one cycle later
  chk_irq_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stat_i.busy |=> !irq)
    else $error("interrupt raised while busy high");

endmodule

// ==== ppp_params.svh ====
// Purpose : Constants for the parallel printer port
// Assumes : 8-bit I/O data bus, 16-bit port addresses
// Notes   : Offsets are the printed I/O port addresses
`ifndef PPP_PARAMS_SVH
`define PPP_PARAMS_SVH

// ----------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------
`define PPP_DATA_ADDR    16'h0250
`define PPP_CTRL_ADDR    16'h0260

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define PPP_CTL_STROBE   0
`define PPP_CTL_AUTONL   1
`define PPP_CTL_INIT     2
`define PPP_CTL_ONLINE   3
`define PPP_CTL_OUTDIS   4
`define PPP_CTL_INTDIS   7

// ----------------------------------------------------------------
// Reset values and vector
// ----------------------------------------------------------------
`define PPP_DATA_RST     8'h00
`define PPP_CTRL_RST     8'h90
`define PPP_INT_VEC_ADDR 20'h00098

`endif

// ==== ppp_pkg.sv ====
// Purpose : Types for the parallel printer port
// Assumes : Used together with ppp_params.svh
// Notes   : Status inputs and control pins travel as structs
package ppp_pkg;

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic ack;
    logic fault;
    logic media_exhausted;
    logic online;
  } ppp_status_in_type;

  typedef struct packed {
    logic strobe_oe;
    logic auto_newline_oe;
    logic init_oe;
    logic online_req_oe;
  } ppp_ctrl_pins_type;

  // ----------------------------------------------------------------
  // Whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data_out_latch;
    logic [7:0] line_control;
    logic [7:0] rd_data;
    logic [7:0] data_o;
    logic       data_oe;
    ppp_ctrl_pins_type ctrl;
    logic       irq;
  } ppp_state_type;

endpackage

// ==== ppp_printer_model.sv ====
// Purpose : Printer side of the parallel port pins
// Assumes : Open-collector control pins have pull-ups
// Notes   : Bench sets status levels and released data levels
`timescale 1ns/100ps

module ppp_printer_model (
  // Port side
  input  wire logic [7:0]                 data_o,
  input  wire logic                       data_oe,
  input  wire ppp_pkg::ppp_ctrl_pins_type ctrl_oe,
  // Bench commands
  input  wire logic [7:0]                 prn_data,
  input  wire ppp_pkg::ppp_status_in_type prn_stat,
  // Resolved pin levels
  output      logic [7:0]                 data_i,
  output      logic [3:0]                 ctrl_pin_i,
  output      ppp_pkg::ppp_status_in_type stat_i
);
  // Port drives the wire, else the printer side does; never floats
  assign data_i = data_oe ? data_o : prn_data;
  // Enabled open collector pulls low, else the pull-up wins
  assign ctrl_pin_i = ~{ctrl_oe.online_req_oe, ctrl_oe.init_oe,
                        ctrl_oe.auto_newline_oe, ctrl_oe.strobe_oe};
  assign stat_i = prn_stat;
endmodule

// ==== tb_top.sv ====
// Purpose : Self-checking bench for the parallel printer port
// Assumes : Read data is taken one cycle after the strobe edge
// Notes   : Expected values come from integer shadows of the registers
`timescale 1ns/100ps
`include "ppp_params.svh"

module tb_top;
  logic                       sys_clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [15:0]                io_addr = 16'h0000;
  logic                       io_wr = 1'b0;
  logic                       io_rd = 1'b0;
  logic [7:0]                 io_wdata = 8'h00;
  logic [7:0]                 io_rdata, data_i, data_o, rd;
  logic [7:0]                 prn_data = 8'h00;
  logic                       irq, data_oe;
  logic [19:0]                irq_vector_addr;
  logic [3:0]                 ctrl_pin_i;
  ppp_pkg::ppp_ctrl_pins_type ctrl_oe;
  ppp_pkg::ppp_status_in_type stat_i;
  ppp_pkg::ppp_status_in_type prn_stat = 5'h1f;
  int                         err_count = 0;
  int                         tests_run = 0;
  int                         m_ctl = 'h90;
  int                         m_dat = 0;
  int                         k;

  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end

  // Clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  ppp_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .irq(irq), .irq_vector_addr(irq_vector_addr), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .ctrl_pin_i(ctrl_pin_i),
    .ctrl_oe(ctrl_oe), .stat_i(stat_i));
  ppp_printer_model prn (.data_o(data_o), .data_oe(data_oe),
    .ctrl_oe(ctrl_oe), .prn_data(prn_data), .prn_stat(prn_stat),
    .data_i(data_i), .ctrl_pin_i(ctrl_pin_i), .stat_i(stat_i));

  // One access; the edge gap keeps strobes from being re-driven at once
  task automatic io_op(input logic wr, input logic [15:0] a,
                       input logic [7:0] d);
    @(posedge sys_clk) #1;
    io_wr = wr; io_rd = !wr; io_addr = a; io_wdata = d;
    @(posedge sys_clk) #1;
    io_wr = 1'b0; io_rd = 1'b0; rd = io_rdata;
    if (wr && a == `PPP_DATA_ADDR) m_dat = d;
    if (wr && a == `PPP_CTRL_ADDR) m_ctl = d;
  endtask

  // Compare reads and pins with the shadow model
  task automatic check_all();
    io_op(1'b0, `PPP_DATA_ADDR, 8'h00);
    `CHK(rd, m_ctl[4] ? prn_data : m_dat[7:0])
    io_op(1'b0, `PPP_CTRL_ADDR, 8'h00);
    `CHK(rd, {m_ctl[3], m_ctl[2], m_ctl[0], ~prn_stat.online, ~prn_stat.media_exhausted, ~prn_stat.fault, ~prn_stat.ack, ~prn_stat.busy})
    `CHK(data_oe, ~m_ctl[4])
    if (!m_ctl[4]) `CHK(data_o, m_dat[7:0])
    `CHK(ctrl_oe, {m_ctl[0], m_ctl[1], m_ctl[2], m_ctl[3]})
    `CHK(irq, !m_ctl[7] && !prn_stat.busy)
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    k = $urandom(32'hbe2b0bca);
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check_all();
    `CHK(irq_vector_addr, 20'h00098)
    // Character send: data, strobe with online, strobe off, masked
    io_op(1'b1, `PPP_DATA_ADDR, 8'h41);
    io_op(1'b1, `PPP_CTRL_ADDR, 8'h89);
    check_all();
    io_op(1'b1, `PPP_CTRL_ADDR, 8'h88);
    prn_stat.busy = 1'b1;
    io_op(1'b1, `PPP_CTRL_ADDR, 8'h08);
    check_all();
    prn_stat.busy = 1'b0;
    check_all();
    io_op(1'b1, `PPP_CTRL_ADDR, 8'h80);
    check_all();
    // Unmapped address reads as zero
    io_op(1'b0, 16'h0251, 8'h00);
    `CHK(rd, 8'h00)
    // Random writes, pin levels and status
    repeat (40) begin
      k = $urandom;
      io_op(1'b1, k[0] ? `PPP_CTRL_ADDR : `PPP_DATA_ADDR, k[15:8]);
      prn_data = k[23:16];
      prn_stat = k[28:24];
      check_all();
    end
    tally_and_finish();
  end
endmodule
